// [logic/relay_select_pkg.sv]
package relay_select_pkg;

	// avalon byte addresses of the register words
	localparam int ADDR_W = 5;
	localparam logic [4:0] RELAY1_SEL_OFS = 5'h00;
	localparam logic [4:0] RELAY2_SEL_OFS = 5'h04;
	localparam logic [4:0] DETECT_FREQ_OFS = 5'h08;
	localparam logic [4:0] DETECT_BAND_OFS = 5'h0c;
	localparam logic [4:0] RELAY_MON_OFS = 5'h10;
	localparam logic [4:0] COND_STATUS_OFS = 5'h14;

	// field widths and relay count
	localparam int SEL_W = 6;
	localparam int FREQ_W = 16;
	localparam int RELAY_N = 2;
	localparam int COND_W = 13;

	// reset values; frequencies in 0.01 Hz steps
	localparam logic [5:0] SEL1_RESET = 6'h1d;
	localparam logic [5:0] SEL2_RESET = 6'h0e;
	localparam logic [15:0] DETECT_FREQ_RESET = 16'h0bb8;
	localparam logic [15:0] DETECT_BAND_RESET = 16'h03e8;

	// selection codes handled here
	localparam logic [5:0] CODE_FDT4 = 6'h04;
	localparam logic [5:0] CODE_OVERLOAD = 6'h05;
	localparam logic [5:0] CODE_IOL_TRIP = 6'h06;
	localparam logic [5:0] CODE_UNDERLOAD = 6'h07;
	localparam logic [5:0] CODE_FAN = 6'h08;
	localparam logic [5:0] CODE_STALL = 6'h09;
	localparam logic [5:0] CODE_OVER_VOLT = 6'h0a;
	localparam logic [5:0] CODE_LOW_VOLT = 6'h0b;
	localparam logic [5:0] CODE_OVER_HEAT = 6'h0c;
	localparam logic [5:0] CODE_LOST_CMD = 6'h0d;
	localparam logic [5:0] CODE_RUN = 6'h0e;
	localparam logic [5:0] CODE_STOP = 6'h0f;
	localparam logic [5:0] CODE_STEADY = 6'h10;

	// bit positions in the condition vector
	localparam int COND_FDT4 = 0;
	localparam int COND_OVERLOAD = 1;
	localparam int COND_IOL_TRIP = 2;
	localparam int COND_UNDERLOAD = 3;
	localparam int COND_FAN = 4;
	localparam int COND_STALL = 5;
	localparam int COND_OVER_VOLT = 6;
	localparam int COND_LOW_VOLT = 7;
	localparam int COND_OVER_HEAT = 8;
	localparam int COND_LOST_CMD = 9;
	localparam int COND_RUN = 10;
	localparam int COND_STOP = 11;
	localparam int COND_STEADY = 12;

endpackage

// [logic/freq_detect_compare.sv]
`timescale 1ns/1ns
module freq_detect_compare (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// frequencies
	input wire logic [15:0] running_freq,
	input wire logic [15:0] detect_frequency_setting,
	input wire logic [15:0] detect_band_width,
	// ramp state
	input wire logic accelerating,
	input wire logic decelerating,
	// detection level
	output logic ramp_dependent_freq_detect
);
	logic [16:0] freq_plus_half;
	logic accel_hit;
	logic decel_hold;
	logic held_reg;

	// freq > det - band/2 rewritten as freq + band/2 > det, so no underflow
	assign freq_plus_half = {1'b0, running_freq} + {2'b00, detect_band_width[15:1]};
	assign accel_hit = running_freq >= detect_frequency_setting;
	assign decel_hold = freq_plus_half > {1'b0, detect_frequency_setting};

	// separate thresholds per ramp direction; level holds at steady speed
	always_comb begin
		if (accelerating) begin
			ramp_dependent_freq_detect = accel_hit;
		end else if (decelerating) begin
			ramp_dependent_freq_detect = decel_hold;
		end else begin
			ramp_dependent_freq_detect = held_reg;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			held_reg <= 1'b0;
		end else begin
			held_reg <= ramp_dependent_freq_detect;
		end
	end
endmodule

// [logic/relay_condition_mux.sv]
`timescale 1ns/1ns
module relay_condition_mux (
	// selection
	input wire logic [5:0] function_select,
	// condition vector
	input wire logic [12:0] cond,
	// chosen level
	output logic relay_level
);
	function automatic logic pick(input logic [5:0] code, input logic [12:0] c);
		logic r;
		r = 1'b0;
		unique case (code)
			relay_select_pkg::CODE_FDT4: r = c[relay_select_pkg::COND_FDT4];
			relay_select_pkg::CODE_OVERLOAD: r = c[relay_select_pkg::COND_OVERLOAD];
			relay_select_pkg::CODE_IOL_TRIP: r = c[relay_select_pkg::COND_IOL_TRIP];
			relay_select_pkg::CODE_UNDERLOAD: r = c[relay_select_pkg::COND_UNDERLOAD];
			relay_select_pkg::CODE_FAN: r = c[relay_select_pkg::COND_FAN];
			relay_select_pkg::CODE_STALL: r = c[relay_select_pkg::COND_STALL];
			relay_select_pkg::CODE_OVER_VOLT: r = c[relay_select_pkg::COND_OVER_VOLT];
			relay_select_pkg::CODE_LOW_VOLT: r = c[relay_select_pkg::COND_LOW_VOLT];
			relay_select_pkg::CODE_OVER_HEAT: r = c[relay_select_pkg::COND_OVER_HEAT];
			relay_select_pkg::CODE_LOST_CMD: r = c[relay_select_pkg::COND_LOST_CMD];
			relay_select_pkg::CODE_RUN: r = c[relay_select_pkg::COND_RUN];
			relay_select_pkg::CODE_STOP: r = c[relay_select_pkg::COND_STOP];
			relay_select_pkg::CODE_STEADY: r = c[relay_select_pkg::COND_STEADY];
			// codes outside 4..16 belong to other logic and read as off here
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	assign relay_level = pick(function_select, cond);
endmodule

// [logic/relay_output_function_select.sv]
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module relay_output_function_select (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// avalon-mm slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// frequency and ramp state
	input wire logic [15:0] running_freq,
	input wire logic accelerating,
	input wire logic decelerating,
	input wire logic steady_run,
	// protection flags
	input wire logic motor_overload,
	input wire logic inverse_time_overload_trip,
	input wire logic underload_warn,
	input wire logic fan_fault_warn,
	input wire logic motor_stall,
	input wire logic dc_over_voltage,
	input wire logic dc_low_voltage,
	input wire logic drive_overheat,
	// command loss
	input wire logic analog_cmd_lost,
	input wire logic rs485_cmd_lost,
	input wire logic option_card_fitted,
	input wire logic option_analog_lost,
	input wire logic option_comm_power_lost,
	// run state
	input wire logic run_cmd,
	input wire logic output_voltage_on,
	input wire logic dc_braking,
	// relay drives
	output logic relay1_on,
	output logic relay2_on
);
	logic [5:0] relay1_function_select_reg;
	logic [5:0] relay2_function_select_reg;
	logic [15:0] detect_frequency_setting_reg;
	logic [15:0] detect_band_width_reg;
	logic [31:0] readdata_reg;
	logic wait_reg;
	logic [1:0] relay_reg;
	logic [1:0] relay_level;
	logic [5:0] sel [2];
	logic [12:0] cond;
	logic fdt4_level;
	logic bus_write;
	logic bus_read;

	// merge a 16-bit field with the two low byte lanes
	function automatic logic [15:0] merge16(input logic [15:0] old,
			input logic [31:0] wd, input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0]) begin
			r[7:0] = wd[7:0];
		end
		if (be[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction

	// bus handshake: one wait cycle, then answer for a single cycle
	assign bus_write = avs_write && !wait_reg;
	assign bus_read = avs_read && wait_reg;
	assign avs_waitrequest = wait_reg;
	assign avs_readdata = readdata_reg;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_reg <= 1'b1;
		end else if (!wait_reg) begin
			wait_reg <= 1'b1;
		end else if (avs_read || avs_write) begin
			wait_reg <= 1'b0;
		end
	end

	// configuration writes; unmapped offsets are ignored
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			relay1_function_select_reg <= relay_select_pkg::SEL1_RESET;
			relay2_function_select_reg <= relay_select_pkg::SEL2_RESET;
			detect_frequency_setting_reg <= relay_select_pkg::DETECT_FREQ_RESET;
			detect_band_width_reg <= relay_select_pkg::DETECT_BAND_RESET;
		end else if (bus_write) begin
			unique case (avs_address)
				relay_select_pkg::RELAY1_SEL_OFS: begin
					if (avs_byteenable[0]) begin
						relay1_function_select_reg <= avs_writedata[5:0];
					end
				end
				relay_select_pkg::RELAY2_SEL_OFS: begin
					if (avs_byteenable[0]) begin
						relay2_function_select_reg <= avs_writedata[5:0];
					end
				end
				relay_select_pkg::DETECT_FREQ_OFS: begin
					detect_frequency_setting_reg <= merge16(detect_frequency_setting_reg,
						avs_writedata, avs_byteenable);
				end
				relay_select_pkg::DETECT_BAND_OFS: begin
					detect_band_width_reg <= merge16(detect_band_width_reg,
						avs_writedata, avs_byteenable);
				end
				default: begin
				end
			endcase
		end
	end

	// read data, loaded while the wait cycle is shown
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			readdata_reg <= 32'h0000_0000;
		end else if (bus_read) begin
			unique case (avs_address)
				relay_select_pkg::RELAY1_SEL_OFS:
					readdata_reg <= {26'h000_0000, relay1_function_select_reg};
				relay_select_pkg::RELAY2_SEL_OFS:
					readdata_reg <= {26'h000_0000, relay2_function_select_reg};
				relay_select_pkg::DETECT_FREQ_OFS:
					readdata_reg <= {16'h0000, detect_frequency_setting_reg};
				relay_select_pkg::DETECT_BAND_OFS:
					readdata_reg <= {16'h0000, detect_band_width_reg};
				relay_select_pkg::RELAY_MON_OFS:
					readdata_reg <= {30'h0000_0000, relay_reg};
				relay_select_pkg::COND_STATUS_OFS:
					readdata_reg <= {19'h0_0000, cond};
				default:
					readdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	freq_detect_compare u_fdt (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.running_freq(running_freq),
		.detect_frequency_setting(detect_frequency_setting_reg),
		.detect_band_width(detect_band_width_reg),
		.accelerating(accelerating),
		.decelerating(decelerating),
		.ramp_dependent_freq_detect(fdt4_level)
	);

	// condition vector indexed by selection code minus four
	always_comb begin
		cond = '0;
		cond[relay_select_pkg::COND_FDT4] = fdt4_level;
		cond[relay_select_pkg::COND_OVERLOAD] = motor_overload;
		cond[relay_select_pkg::COND_IOL_TRIP] = inverse_time_overload_trip;
		cond[relay_select_pkg::COND_UNDERLOAD] = underload_warn;
		cond[relay_select_pkg::COND_FAN] = fan_fault_warn;
		cond[relay_select_pkg::COND_STALL] = motor_overload && motor_stall;
		cond[relay_select_pkg::COND_OVER_VOLT] = dc_over_voltage;
		cond[relay_select_pkg::COND_LOW_VOLT] = dc_low_voltage;
		cond[relay_select_pkg::COND_OVER_HEAT] = drive_overheat;
		cond[relay_select_pkg::COND_LOST_CMD] = analog_cmd_lost || rs485_cmd_lost
			|| (option_card_fitted && (option_analog_lost || option_comm_power_lost));
		cond[relay_select_pkg::COND_RUN] = run_cmd && output_voltage_on
			&& !dc_braking;
		cond[relay_select_pkg::COND_STOP] = !run_cmd && !output_voltage_on;
		cond[relay_select_pkg::COND_STEADY] = steady_run;
	end

	assign sel[0] = relay1_function_select_reg;
	assign sel[1] = relay2_function_select_reg;

	// one selector and output flop per relay
	generate
		for (genvar i = 0; i < relay_select_pkg::RELAY_N; i++) begin : g_relay
			relay_condition_mux u_mux (
				.function_select(sel[i]),
				.cond(cond),
				.relay_level(relay_level[i])
			);
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					relay_reg[i] <= 1'b0;
				end else begin
					relay_reg[i] <= relay_level[i];
				end
			end
		end
	endgenerate

	assign relay1_on = relay_reg[0];
	assign relay2_on = relay_reg[1];

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	logic [16:0] chk_thresh;
	assign chk_thresh = {1'b0, running_freq} + {2'b00, detect_band_width_reg[15:1]};

	property p_fdt4_accel;
		relay1_function_select_reg == relay_select_pkg::CODE_FDT4 && accelerating
			|=> relay1_on == $past(running_freq >= detect_frequency_setting_reg);
	endproperty
	a_fdt4_accel: assert property (p_fdt4_accel) else $error("accel detect wrong");

	property p_fdt4_decel;
		relay1_function_select_reg == relay_select_pkg::CODE_FDT4 && !accelerating
			&& decelerating |=> relay1_on == $past(chk_thresh > {1'b0, detect_frequency_setting_reg});
	endproperty
	a_fdt4_decel: assert property (p_fdt4_decel) else $error("decel detect wrong");

	property p_overload;
		relay2_function_select_reg == relay_select_pkg::CODE_OVERLOAD
			|=> relay2_on == $past(motor_overload);
	endproperty
	a_overload: assert property (p_overload) else $error("overload relay wrong");

	property p_stall;
		relay1_function_select_reg == relay_select_pkg::CODE_STALL
			|=> relay1_on == ($past(motor_overload) && $past(motor_stall));
	endproperty
	a_stall: assert property (p_stall) else $error("stall relay wrong");

	property p_iol_trip;
		relay1_function_select_reg == relay_select_pkg::CODE_IOL_TRIP
			|=> relay1_on == $past(inverse_time_overload_trip);
	endproperty
	a_iol_trip: assert property (p_iol_trip) else $error("trip relay wrong");

	property p_underload;
		relay1_function_select_reg == relay_select_pkg::CODE_UNDERLOAD
			|=> relay1_on == $past(underload_warn);
	endproperty
	a_underload: assert property (p_underload) else $error("underload relay wrong");

	property p_fan;
		relay1_function_select_reg == relay_select_pkg::CODE_FAN
			|=> relay1_on == $past(fan_fault_warn);
	endproperty
	a_fan: assert property (p_fan) else $error("fan relay wrong");

	property p_over_volt;
		relay1_function_select_reg == relay_select_pkg::CODE_OVER_VOLT
			|=> relay1_on == $past(dc_over_voltage);
	endproperty
	a_over_volt: assert property (p_over_volt) else $error("overvoltage relay wrong");

	property p_low_volt;
		relay1_function_select_reg == relay_select_pkg::CODE_LOW_VOLT
			|=> relay1_on == $past(dc_low_voltage);
	endproperty
	a_low_volt: assert property (p_low_volt) else $error("low voltage relay wrong");

	property p_over_heat;
		relay1_function_select_reg == relay_select_pkg::CODE_OVER_HEAT
			|=> relay1_on == $past(drive_overheat);
	endproperty
	a_over_heat: assert property (p_over_heat) else $error("overheat relay wrong");

	property p_lost_card_analog;
		relay1_function_select_reg == relay_select_pkg::CODE_LOST_CMD && option_card_fitted
			&& option_analog_lost |=> relay1_on;
	endproperty
	a_lost_card_analog: assert property (p_lost_card_analog) else $error("card analog loss missed");

	property p_steady;
		relay2_function_select_reg == relay_select_pkg::CODE_STEADY
			|=> relay2_on == $past(steady_run);
	endproperty
	a_steady: assert property (p_steady) else $error("steady relay wrong");

	property p_lost;
		relay1_function_select_reg == relay_select_pkg::CODE_LOST_CMD && !option_card_fitted
			|=> relay1_on == ($past(analog_cmd_lost) || $past(rs485_cmd_lost));
	endproperty
	a_lost: assert property (p_lost) else $error("lost command relay wrong");

	property p_lost_card;
		relay1_function_select_reg == relay_select_pkg::CODE_LOST_CMD && option_card_fitted
			&& option_comm_power_lost |=> relay1_on;
	endproperty
	a_lost_card: assert property (p_lost_card) else $error("card loss missed");

	property p_run_brake;
		relay2_function_select_reg == relay_select_pkg::CODE_RUN && dc_braking |=> !relay2_on;
	endproperty
	a_run_brake: assert property (p_run_brake) else $error("run on in braking");

	property p_run;
		relay2_function_select_reg == relay_select_pkg::CODE_RUN && !dc_braking
			|=> relay2_on == ($past(run_cmd) && $past(output_voltage_on));
	endproperty
	a_run: assert property (p_run) else $error("run relay wrong");

	property p_stop;
		relay1_function_select_reg == relay_select_pkg::CODE_STOP
			|=> relay1_on == (!$past(run_cmd) && !$past(output_voltage_on));
	endproperty
	a_stop: assert property (p_stop) else $error("stop relay wrong");

	property p_unused_code;
		relay2_function_select_reg < relay_select_pkg::CODE_FDT4
			|| relay2_function_select_reg > relay_select_pkg::CODE_STEADY |=> !relay2_on;
	endproperty
	a_unused_code: assert property (p_unused_code) else $error("idle code drove relay");

	property p_monitor;
		avs_read && wait_reg && avs_address == relay_select_pkg::RELAY_MON_OFS
			|=> !avs_waitrequest && avs_readdata[1:0] == $past(relay_reg);
	endproperty
	a_monitor: assert property (p_monitor) else $error("monitor readback wrong");

	property p_bus_answer;
		(avs_read || avs_write) && wait_reg |=> !avs_waitrequest ##1 avs_waitrequest;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing wrong");

	c_fdt4_on: cover property (relay1_function_select_reg == relay_select_pkg::CODE_FDT4
		&& decelerating ##1 relay1_on);
	c_both_on: cover property (relay1_on && relay2_on);
	c_mon_read: cover property (avs_read && avs_address == relay_select_pkg::RELAY_MON_OFS
		&& !avs_waitrequest);
endmodule

// [testbench/relay_contacts.sv]
`timescale 1ns/1ns
module relay_contacts (
	// coil drives
	input wire logic sys_clk,
	input wire logic relay1_on,
	input wire logic relay2_on,
	// contact state seen by field wiring
	output logic [1:0] contact_closed
);
	// contacts pick up one clock after the coil, as a slow armature would
	always_ff @(posedge sys_clk) begin
		contact_closed <= {relay2_on, relay1_on};
	end
endmodule

// [testbench/relay_output_function_select_bench.sv]
`timescale 1ns/1ns
module relay_output_function_select_bench;
	logic sys_clk, rst_n, avs_read, avs_write, avs_waitrequest;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0] avs_byteenable;
	logic [15:0] running_freq;
	logic accelerating, decelerating;
	logic [16:0] flags;
	logic steady_run, dc_braking, output_voltage_on, run_cmd, option_comm_power_lost;
	logic option_analog_lost, option_card_fitted, rs485_cmd_lost, analog_cmd_lost;
	logic drive_overheat, dc_low_voltage, dc_over_voltage, motor_stall, fan_fault_warn;
	logic underload_warn, inverse_time_overload_trip, motor_overload, relay1_on, relay2_on;
	logic [1:0] contact_closed;
	int mismatches, total_checks;
	// code, flags that must energise, flags that must not
	localparam logic [39:0] TBL [16] = '{
		{6'h05, 17'h00001, 17'h1fffe}, {6'h06, 17'h00002, 17'h1fffd},
		{6'h07, 17'h00004, 17'h1fffb}, {6'h08, 17'h00008, 17'h1fff7},
		{6'h09, 17'h00011, 17'h00010}, {6'h09, 17'h00011, 17'h00001},
		{6'h0a, 17'h00020, 17'h1ffdf}, {6'h0b, 17'h00040, 17'h1ffbf},
		{6'h0c, 17'h00080, 17'h1ff7f}, {6'h0d, 17'h00100, 17'h01800},
		{6'h0d, 17'h00200, 17'h00000}, {6'h0d, 17'h00c00, 17'h00000},
		{6'h0d, 17'h01400, 17'h01000}, {6'h0e, 17'h06000, 17'h0e000},
		{6'h0f, 17'h00000, 17'h04000}, {6'h10, 17'h10000, 17'h0ffff}
	};
	// accel, decel, frequency, expected level
	localparam logic [18:0] FDT [10] = '{
		{2'b10, 16'h0bb7, 1'b0}, {2'b10, 16'h0bb8, 1'b1}, {2'b01, 16'h09c5, 1'b1},
		{2'b01, 16'h09c4, 1'b0}, {2'b11, 16'h0a28, 1'b0}, {2'b01, 16'h0a28, 1'b1},
		{2'b00, 16'h07d0, 1'b1}, {2'b01, 16'h079f, 1'b1}, {2'b01, 16'h079e, 1'b0},
		{2'b10, 16'h07d0, 1'b1}
	};
	assign {steady_run, dc_braking, output_voltage_on, run_cmd, option_comm_power_lost,
		option_analog_lost, option_card_fitted, rs485_cmd_lost, analog_cmd_lost,
		drive_overheat, dc_low_voltage, dc_over_voltage, motor_stall, fan_fault_warn,
		underload_warn, inverse_time_overload_trip, motor_overload} = flags;
	relay_output_function_select relay_output_function_select_inst (
		.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .running_freq(running_freq),
		.accelerating(accelerating), .decelerating(decelerating), .steady_run(steady_run),
		.motor_overload(motor_overload),
		.inverse_time_overload_trip(inverse_time_overload_trip),
		.underload_warn(underload_warn), .fan_fault_warn(fan_fault_warn),
		.motor_stall(motor_stall), .dc_over_voltage(dc_over_voltage),
		.dc_low_voltage(dc_low_voltage), .drive_overheat(drive_overheat),
		.analog_cmd_lost(analog_cmd_lost), .rs485_cmd_lost(rs485_cmd_lost),
		.option_card_fitted(option_card_fitted), .option_analog_lost(option_analog_lost),
		.option_comm_power_lost(option_comm_power_lost), .run_cmd(run_cmd),
		.output_voltage_on(output_voltage_on), .dc_braking(dc_braking),
		.relay1_on(relay1_on), .relay2_on(relay2_on)
	);
	relay_contacts relay_contacts_inst (
		.sys_clk(sys_clk), .relay1_on(relay1_on), .relay2_on(relay2_on),
		.contact_closed(contact_closed)
	);
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0 && n < 16) begin
			@(posedge sys_clk);
			n++;
		end
		if (n == 16) mismatches++;
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic apply(input logic [16:0] f, input logic [15:0] fr, input logic [1:0] ad);
		@(posedge sys_clk);
		flags <= f;
		running_freq <= fr;
		{accelerating, decelerating} <= ad;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	task automatic test_regs;
		bus(1'b0, relay_select_pkg::RELAY1_SEL_OFS, 32'h0);
		check(rd, {26'h0, relay_select_pkg::SEL1_RESET});
		bus(1'b0, relay_select_pkg::RELAY2_SEL_OFS, 32'h0);
		check(rd, {26'h0, relay_select_pkg::SEL2_RESET});
		bus(1'b0, relay_select_pkg::DETECT_FREQ_OFS, 32'h0);
		check(rd, {16'h0, relay_select_pkg::DETECT_FREQ_RESET});
		bus(1'b0, relay_select_pkg::DETECT_BAND_OFS, 32'h0);
		check(rd, {16'h0, relay_select_pkg::DETECT_BAND_RESET});
		bus(1'b1, relay_select_pkg::RELAY_MON_OFS, 32'hffff_ffff);
		bus(1'b0, relay_select_pkg::RELAY_MON_OFS, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, 5'h18, 32'h0);
		check(rd, 32'h0);
		$display("test regs done");
	endtask
	task automatic test_codes;
		logic [39:0] e;
		bus(1'b1, relay_select_pkg::RELAY2_SEL_OFS, 32'h0);
		for (int i = 0; i < 16; i++) begin
			e = TBL[i];
			bus(1'b1, relay_select_pkg::RELAY1_SEL_OFS, {26'h0, e[39:34]});
			apply(e[33:17], 16'h0, 2'b00);
			check({31'h0, relay1_on}, 32'h1);
			check({31'h0, relay2_on}, 32'h0);
			bus(1'b0, relay_select_pkg::COND_STATUS_OFS, 32'h0);
			check({31'h0, rd[e[39:34] - 6'h04]}, 32'h1);
			apply(e[16:0], 16'h0, 2'b00);
			check({31'h0, relay1_on}, 32'h0);
		end
		$display("test codes done");
	endtask
	task automatic test_fdt;
		bus(1'b1, relay_select_pkg::RELAY1_SEL_OFS, {26'h0, relay_select_pkg::CODE_FDT4});
		for (int i = 0; i < 10; i++) begin
			if (i == 7) begin
				bus(1'b1, relay_select_pkg::DETECT_FREQ_OFS, 32'h0000_07d0);
				bus(1'b1, relay_select_pkg::DETECT_BAND_OFS, 32'h0000_0064);
			end
			apply(17'h0, FDT[i][16:1], FDT[i][18:17]);
			check({31'h0, relay1_on}, {31'h0, FDT[i][0]});
		end
		$display("test fdt done");
	endtask
	task automatic test_pair;
		logic [1:0] v;
		bus(1'b1, relay_select_pkg::RELAY1_SEL_OFS, {26'h0, relay_select_pkg::CODE_OVERLOAD});
		bus(1'b1, relay_select_pkg::RELAY2_SEL_OFS, {26'h0, relay_select_pkg::CODE_STEADY});
		for (int i = 0; i < 4; i++) begin
			v = i[1:0];
			apply({v[1], 15'h0, v[0]}, 16'h0, 2'b00);
			check({30'h0, relay2_on, relay1_on}, {30'h0, v});
			check({30'h0, contact_closed}, {30'h0, v});
			bus(1'b0, relay_select_pkg::RELAY_MON_OFS, 32'h0);
			check(rd, {30'h0, v});
		end
		$display("test pair done");
	endtask
	task automatic test_relay2;
		bus(1'b1, relay_select_pkg::RELAY1_SEL_OFS, {26'h0, relay_select_pkg::CODE_STOP});
		bus(1'b1, relay_select_pkg::RELAY2_SEL_OFS, {26'h0, relay_select_pkg::CODE_RUN});
		apply(17'h0e000, 16'h0, 2'b00);
		check({30'h0, relay2_on, relay1_on}, 32'h0);
		apply(17'h06000, 16'h0, 2'b00);
		check({30'h0, relay2_on, relay1_on}, 32'h2);
		apply(17'h00000, 16'h0, 2'b00);
		check({30'h0, relay2_on, relay1_on}, 32'h1);
		bus(1'b1, relay_select_pkg::RELAY2_SEL_OFS, {26'h0, relay_select_pkg::CODE_OVERLOAD});
		apply(17'h00001, 16'h0, 2'b00);
		check({30'h0, relay2_on, relay1_on}, 32'h3);
		bus(1'b1, relay_select_pkg::RELAY2_SEL_OFS, 32'h0000_0011);
		apply(17'h1ffff, 16'h0, 2'b00);
		check({31'h0, relay2_on}, 32'h0);
		$display("test relay2 done");
	endtask
	task automatic end_of_test;
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		mismatches = 0;
		total_checks = 0;
		rst_n = 1'b0;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		running_freq = 16'h0;
		accelerating = 1'b0;
		decelerating = 1'b0;
		flags = 17'h0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		test_regs();
		test_codes();
		test_fdt();
		test_pair();
		test_relay2();
		end_of_test();
	end
	// whole run needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		end_of_test();
	end
endmodule
